// ==== verilog/flash_host_ctrl.sv ====
/*
 * apb-programmed host controller for an asynchronous parallel flash:
 * read cycles, command writes, two-write sequences, otp lock and reset pulse.
 * assumes flash pins are synchronous to ref_clk_i and data_lines are resolved
 * outside from data_lines_oe_n; apb slave answers with zero wait states.
 */
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/100ps

module flash_host_ctrl #(
    parameter int RESET_TO_OUTPUT_NS = 1000,  // wake-up time before first read
    parameter int RESET_TO_WRITE_NS  = 1000   // wake-up time before first write
) (
    input  wire logic                              ref_clk_i,      // 100 MHz clock
    input  wire logic                              rst_i,          // sync reset, high
    input  wire logic                              psel_i,         // apb select
    input  wire logic                              penable_i,      // apb access phase
    input  wire logic                              pwrite_i,       // apb write
    input  wire logic [11:0]                       paddr_i,        // apb byte address
    input  wire logic [31:0]                       pwdata_i,       // apb write data
    output logic      [31:0]                       prdata_o,       // apb read data
    output logic                                   pready_o,       // apb ready
    output logic                                   pslverr_o,      // apb error
    input  wire logic [flash_host_pkg::DATA_W-1:0] data_lines_i,   // flash data in
    input  wire logic                              ready_busy_n_i, // flash busy pin level
    output flash_host_pkg::flash_out_type          flash_o         // all driven pins
);

    // wake-up counts, rounded up; the sequencer waits the longer of the two
    localparam int OUT_CYC = (RESET_TO_OUTPUT_NS + flash_host_pkg::CLK_PERIOD_NS - 1)
                             / flash_host_pkg::CLK_PERIOD_NS;
    localparam int WR_CYC  = (RESET_TO_WRITE_NS + flash_host_pkg::CLK_PERIOD_NS - 1)
                             / flash_host_pkg::CLK_PERIOD_NS;
    localparam int REC_RAW = (OUT_CYC > WR_CYC) ? OUT_CYC : WR_CYC;
    localparam int REC_CYC = (REC_RAW < 1) ? 1 : REC_RAW;
    localparam logic [flash_host_pkg::TMR_W-1:0] RECOVER_CNT =
        flash_host_pkg::TMR_W'(REC_CYC);
    localparam logic [flash_host_pkg::TMR_W-1:0] RESET_LOW_CNT =
        flash_host_pkg::TMR_W'(flash_host_pkg::RESET_LOW_CYC);
    localparam logic [flash_host_pkg::TMR_W-1:0] ONE_CNT = 16'h0001;

    // sequencer state
    flash_host_pkg::state_type state_reg, state_next;

    // software-visible registers
    logic [flash_host_pkg::ADDR_W-1:0] addr_reg;     // target address
    logic [flash_host_pkg::DATA_W-1:0] wdata_reg;    // data of second write
    logic [flash_host_pkg::DATA_W-1:0] rdata_reg;    // captured read data
    logic [7:0]                        strobe_reg;   // strobe width in cycles
    logic                              refused_reg;  // sticky refused access
    logic                              idmode_reg;   // device believed in id mode
    logic                              idmode_next;

    // per-operation registers
    logic [2:0]                        op_reg;       // running operation
    logic [7:0]                        cmd_reg;      // first-write command byte
    logic                              second_reg;   // second write in progress
    logic                              second_next;

    // pin levels for the next cycle
    flash_host_pkg::flash_out_type     pins_next;

    // timer hookup
    logic                              tmr_load;
    logic [flash_host_pkg::TMR_W-1:0]  tmr_value;
    logic                              tmr_done;

    // apb decode
    wire access    = psel_i & penable_i;
    wire idle      = (state_reg == flash_host_pkg::S_IDLE);
    wire hit_ctrl  = (paddr_i == flash_host_pkg::OFS_CTRL);
    wire hit_addr  = (paddr_i == flash_host_pkg::OFS_ADDR);
    wire hit_wdata = (paddr_i == flash_host_pkg::OFS_WDATA);
    wire hit_rdata = (paddr_i == flash_host_pkg::OFS_RDATA);
    wire hit_stat  = (paddr_i == flash_host_pkg::OFS_STATUS);
    wire hit_tim   = (paddr_i == flash_host_pkg::OFS_TIMING);
    wire mapped    = hit_ctrl | hit_addr | hit_wdata | hit_rdata | hit_stat | hit_tim;
    wire wr        = access & pwrite_i;
    // configuration may only change while the flash bus is quiet
    wire cfg_wr    = wr & (hit_ctrl | hit_addr | hit_wdata | hit_tim);
    wire cfg_ok    = cfg_wr & idle;
    wire refuse    = cfg_wr & ~idle;
    wire start     = cfg_ok & hit_ctrl;
    wire clr_ref   = wr & hit_stat & pwdata_i[flash_host_pkg::ST_REFUSED];
    wire [2:0] new_op  = pwdata_i[flash_host_pkg::CTRL_OP_LSB +: 3];
    wire [7:0] new_cmd = pwdata_i[flash_host_pkg::CTRL_CMD_LSB +: 8];
    wire op_is_read    = (op_reg == flash_host_pkg::OP_READ);
    wire op_two_write  = (op_reg == flash_host_pkg::OP_SEQ) |
                         (op_reg == flash_host_pkg::OP_OTP_LOCK);

    // status word
    wire [31:0] status_word = {27'h0000000,
                               idmode_reg,
                               refused_reg,
                               (state_reg == flash_host_pkg::S_RECOVER),
                               ready_busy_n_i,
                               ~idle};

    // read mux; unmapped reads give zero and an error
    assign prdata_o  = hit_ctrl  ? {16'h0000, cmd_reg, 5'h00, op_reg} :
                       hit_addr  ? {11'h000, addr_reg} :
                       hit_wdata ? {16'h0000, wdata_reg} :
                       hit_rdata ? {16'h0000, rdata_reg} :
                       hit_stat  ? status_word :
                       hit_tim   ? {24'h000000, strobe_reg} : 32'h00000000;
    assign pready_o  = 1'b1;                 // zero wait states
    assign pslverr_o = access & ~mapped;

    // data driven in each write: command byte first, then the second word
    wire [flash_host_pkg::DATA_W-1:0] second_data =
        (op_reg == flash_host_pkg::OP_OTP_LOCK) ? flash_host_pkg::OTP_LOCK_DATA : wdata_reg;
    wire [flash_host_pkg::ADDR_W-1:0] second_addr =
        (op_reg == flash_host_pkg::OP_OTP_LOCK) ? flash_host_pkg::OTP_LOCK_ADDR : addr_reg;
    wire [flash_host_pkg::DATA_W-1:0] cur_data = second_reg ? second_data : {8'h00, cmd_reg};
    wire [flash_host_pkg::ADDR_W-1:0] cur_addr = second_reg ? second_addr : addr_reg;

    // next state
    always_comb begin
        state_next  = state_reg;
        second_next = second_reg;
        case (state_reg)
            flash_host_pkg::S_IDLE: begin
                if (start) begin
                    // a reset pulse needs no bus cycle
                    state_next  = (new_op == flash_host_pkg::OP_RESET) ?
                                  flash_host_pkg::S_RST_LOW : flash_host_pkg::S_SETUP;
                    second_next = 1'b0;
                end
            end
            flash_host_pkg::S_SETUP: begin
                state_next = flash_host_pkg::S_STROBE;
            end
            flash_host_pkg::S_STROBE: begin
                if (tmr_done) begin
                    state_next = flash_host_pkg::S_HOLD;
                end
            end
            flash_host_pkg::S_HOLD: begin
                state_next = flash_host_pkg::S_GAP;
            end
            flash_host_pkg::S_GAP: begin
                // confirm write follows its command with no software gap
                if (op_two_write & ~second_reg) begin
                    state_next  = flash_host_pkg::S_SETUP;
                    second_next = 1'b1;
                end else begin
                    state_next  = flash_host_pkg::S_IDLE;
                    second_next = 1'b0;
                end
            end
            flash_host_pkg::S_RST_LOW: begin
                if (tmr_done) begin
                    state_next = flash_host_pkg::S_RECOVER;
                end
            end
            flash_host_pkg::S_RECOVER: begin
                // no access until both wake-up delays are over
                if (tmr_done) begin
                    state_next = flash_host_pkg::S_IDLE;
                end
            end
            default: begin
                state_next = flash_host_pkg::S_IDLE;
            end
        endcase
    end

    // timer reload on every state change, length chosen by the new state
    assign tmr_load  = (state_next != state_reg);
    assign tmr_value = (state_next == flash_host_pkg::S_STROBE)  ?
                           {8'h00, strobe_reg} :
                       (state_next == flash_host_pkg::S_RST_LOW) ? RESET_LOW_CNT :
                       (state_next == flash_host_pkg::S_RECOVER) ? RECOVER_CNT : ONE_CNT;

    // pin levels per state
    always_comb begin
        pins_next = flash_host_pkg::PINS_RESET;
        pins_next.reset_powerdown_n = 1'b1;
        pins_next.addr              = cur_addr;
        pins_next.data_lines        = cur_data;
        case (state_reg)
            flash_host_pkg::S_SETUP: begin
                pins_next.chip_sel_n      = 1'b0;
                pins_next.data_lines_oe_n = op_is_read;
            end
            flash_host_pkg::S_STROBE: begin
                pins_next.chip_sel_n      = 1'b0;
                // only one of the two strobes is ever low
                pins_next.out_en_n        = ~op_is_read;
                pins_next.write_en_n      = op_is_read;
                pins_next.data_lines_oe_n = op_is_read;
            end
            flash_host_pkg::S_HOLD: begin
                // write enable rises first, so it alone latches address and data
                pins_next.chip_sel_n      = 1'b0;
                pins_next.data_lines_oe_n = op_is_read;
            end
            flash_host_pkg::S_RST_LOW: begin
                pins_next.reset_powerdown_n = 1'b0;
            end
            default: begin
                // idle, gap and recover: deselected, bus released
                pins_next.chip_sel_n = 1'b1;
            end
        endcase
    end

    // device mode tracking: reset returns it to array mode
    always_comb begin
        idmode_next = idmode_reg;
        if (state_reg == flash_host_pkg::S_RST_LOW) begin
            idmode_next = 1'b0;
        end else if (state_reg == flash_host_pkg::S_HOLD & ~op_is_read & ~second_reg) begin
            if (cmd_reg == flash_host_pkg::CMD_READ_ID) begin
                idmode_next = 1'b1;
            end else if (cmd_reg == flash_host_pkg::CMD_READ_ARRAY) begin
                idmode_next = 1'b0;
            end
        end
    end

    // state and operation registers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            // wake with the flash held low long enough, then wait it out
            state_reg  <= flash_host_pkg::S_RST_LOW;
            second_reg <= 1'b0;
            idmode_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            second_reg <= second_next;
            idmode_reg <= idmode_next;
        end
    end

    // software registers; writes while busy are dropped and flagged
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            addr_reg   <= '0;
            wdata_reg  <= '0;
            strobe_reg <= flash_host_pkg::STROBE_CYC_RST;
            op_reg     <= flash_host_pkg::OP_READ;
            cmd_reg    <= flash_host_pkg::CMD_READ_ARRAY;
        end else begin
            if (cfg_ok & hit_addr) begin
                addr_reg <= pwdata_i[flash_host_pkg::ADDR_W-1:0];
            end
            if (cfg_ok & hit_wdata) begin
                wdata_reg <= pwdata_i[flash_host_pkg::DATA_W-1:0];
            end
            if (cfg_ok & hit_tim) begin
                // too short a strobe would leave no settled data to sample
                strobe_reg <= (pwdata_i[7:0] < flash_host_pkg::STROBE_CYC_MIN) ?
                              flash_host_pkg::STROBE_CYC_MIN : pwdata_i[7:0];
            end
            if (start) begin
                op_reg  <= new_op;
                cmd_reg <= new_cmd;
            end
        end
    end

    // refused flag: a new refusal wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            refused_reg <= 1'b0;
        end else if (refuse) begin
            refused_reg <= 1'b1;
        end else if (clr_ref) begin
            refused_reg <= 1'b0;
        end
    end

    // read data sampled on the last strobe cycle, output enable still low
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
        end else if (state_reg == flash_host_pkg::S_STROBE & tmr_done & op_is_read) begin
            rdata_reg <= data_lines_i;
        end
    end

    // interval timer, starts counting the reset pulse straight out of reset
    flash_cycle_timer #(
        .INIT_COUNT (RESET_LOW_CNT - 16'h0001)
    ) u_timer (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .load_i    (tmr_load),
        .value_i   (tmr_value),
        .done_o    (tmr_done)
    );

    // registered pins
    flash_pin_register u_pins (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .pins_next_i (pins_next),
        .pins_o      (flash_o)
    );

endmodule

// ==== verilog/flash_host_pkg.sv ====
/*
 * constants, types and register map of the parallel flash host controller.
 * assumes a 100 MHz reference clock and a 16-bit flash with a 21-bit word address.
 */
package flash_host_pkg;

    // widths
    localparam int ADDR_W = 21;                     // flash word address
    localparam int DATA_W = 16;                     // data_lines width
    localparam int TMR_W  = 16;                     // timer width

    // apb register offsets, one aligned word each
    localparam logic [11:0] OFS_CTRL   = 12'h000;   // write starts an operation
    localparam logic [11:0] OFS_ADDR   = 12'h004;   // target flash address
    localparam logic [11:0] OFS_WDATA  = 12'h008;   // data of the second write
    localparam logic [11:0] OFS_RDATA  = 12'h00C;   // last read result
    localparam logic [11:0] OFS_STATUS = 12'h010;   // controller state
    localparam logic [11:0] OFS_TIMING = 12'h014;   // strobe width in cycles

    // ctrl fields
    localparam int CTRL_OP_LSB  = 0;                // op code, 3 bits
    localparam int CTRL_CMD_LSB = 8;                // command byte, 8 bits

    // status fields
    localparam int ST_BUSY    = 0;                  // operation in progress
    localparam int ST_RYBY    = 1;                  // ready_busy_n pin level
    localparam int ST_RECOVER = 2;                  // waiting after reset
    localparam int ST_REFUSED = 3;                  // sticky, write 1 clears
    localparam int ST_IDMODE  = 4;                  // device left in identifier mode

    // operation codes
    localparam logic [2:0] OP_READ     = 3'h0;      // one read cycle
    localparam logic [2:0] OP_CMD      = 3'h1;      // one command write
    localparam logic [2:0] OP_SEQ      = 3'h2;      // command then data write
    localparam logic [2:0] OP_OTP_LOCK = 3'h3;      // lock customer otp area
    localparam logic [2:0] OP_RESET    = 3'h4;      // pulse reset_powerdown_n

    // flash commands and fixed data
    localparam logic [7:0]        CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0]        CMD_READ_ID    = 8'h90;
    localparam logic [7:0]        CMD_OTP_PROG   = 8'hC0;
    localparam logic [DATA_W-1:0] OTP_LOCK_DATA  = 16'hFFFD;
    localparam logic [ADDR_W-1:0] OTP_LOCK_ADDR  = 21'h000080;

    // timing
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          RESET_LOW_NS   = 100;
    localparam int          RESET_LOW_CYC  = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  STROBE_CYC_RST = 8'h04;  // timing register reset value
    localparam logic [7:0]  STROBE_CYC_MIN = 8'h02;  // shorter widths are raised to this

    // sequencer states, gray along setup-strobe-hold-gap
    typedef enum logic [2:0] {
        S_IDLE    = 3'b000,
        S_SETUP   = 3'b001,
        S_STROBE  = 3'b011,
        S_HOLD    = 3'b010,
        S_GAP     = 3'b110,
        S_RST_LOW = 3'b111,
        S_RECOVER = 3'b101
    } state_type;

    // every pin that the host drives toward the flash
    typedef struct packed {
        logic                reset_powerdown_n;
        logic                chip_sel_n;
        logic                out_en_n;
        logic                write_en_n;
        logic                data_lines_oe_n;    // low while host drives data_lines
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data_lines;
    } flash_out_type;

    // pins during system reset: flash held in reset, bus released
    localparam flash_out_type PINS_RESET = '{
        reset_powerdown_n: 1'b0, chip_sel_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1,
        data_lines_oe_n: 1'b1, addr: '0, data_lines: '0};

endpackage

// ==== verilog/flash_cycle_timer.sv ====
/*
 * down counter that times each sequencer state.
 * assumes load values of one or more; a load of n gives done after n cycles.
 */
`timescale 1ns/100ps

module flash_cycle_timer #(
    parameter logic [flash_host_pkg::TMR_W-1:0] INIT_COUNT = '0  // count taken at reset
) (
    input  wire logic                             ref_clk_i,  // 100 MHz clock
    input  wire logic                             rst_i,      // sync reset, high
    input  wire logic                             load_i,     // reload the count
    input  wire logic [flash_host_pkg::TMR_W-1:0] value_i,    // cycles to time
    output logic                                  done_o      // last cycle of interval
);

    logic [flash_host_pkg::TMR_W-1:0] count_reg;  // remaining cycles minus one
    logic [flash_host_pkg::TMR_W-1:0] count_next;

    // reload wins over counting; stop at zero
    assign count_next = load_i      ? value_i - 16'h0001 :
                        (|count_reg) ? count_reg - 16'h0001 : count_reg;
    assign done_o     = ~|count_reg;

    // counter
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_reg <= INIT_COUNT;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule

// ==== verilog/flash_pin_register.sv ====
/*
 * output flops for every flash pin, so the pins never glitch.
 * assumes the sequencer computes the next pin levels one cycle ahead.
 */
`timescale 1ns/100ps

module flash_pin_register (
    input  wire logic                          ref_clk_i,   // 100 MHz clock
    input  wire logic                          rst_i,       // sync reset, high
    input  wire flash_host_pkg::flash_out_type pins_next_i, // levels for next cycle
    output flash_host_pkg::flash_out_type      pins_o       // registered pins
);

    // system reset holds the flash in reset too; the sequencer then keeps it low for the reset pulse
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pins_o <= flash_host_pkg::PINS_RESET;
        end else begin
            pins_o <= pins_next_i;
        end
    end

endmodule

// ==== tb/flash_host_ctrl_sva.sv ====
/* assertions on the flash pins of the host controller.
   assumes a bind to flash_host_ctrl, one clock and a sync reset. */
`timescale 1ns/100ps
module flash_host_ctrl_sva (
    input wire logic                          ref_clk_i, // clock
    input wire logic                          rst_i,     // sync reset
    input wire flash_host_pkg::flash_out_type flash_o    // flash pins
);
    logic [7:0] low_cnt = 8'h00; // reset pin low cycles, saturating
    // counts through system reset too, since the pin is low then
    always_ff @(posedge ref_clk_i) begin
        if (flash_o.reset_powerdown_n) low_cnt <= 8'h00;
        else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence we_release; $rose(flash_o.write_en_n); endsequence
    sequence ce_after; !flash_o.chip_sel_n ##1 flash_o.chip_sel_n; endsequence
    strobe_clash_a: assert property (!(!flash_o.out_en_n && !flash_o.write_en_n))
        else $error("output and write enable low together");
    read_pins_a: assert property (!flash_o.out_en_n |-> !flash_o.chip_sel_n &&
        flash_o.write_en_n && flash_o.reset_powerdown_n && flash_o.data_lines_oe_n)
        else $error("read strobe with wrong pins");
    write_pins_a: assert property (!flash_o.write_en_n |-> !flash_o.chip_sel_n &&
        !flash_o.data_lines_oe_n && flash_o.reset_powerdown_n)
        else $error("write strobe with wrong pins");
    write_latch_a: assert property (we_release |-> $stable(flash_o.addr) and ce_after)
        else $error("write enable did not rise before chip select");
    reset_width_a: assert property ($rose(flash_o.reset_powerdown_n) |-> low_cnt >= 8'h0A)
        else $error("reset pulse too short");
    reset_quiet_a: assert property (!flash_o.reset_powerdown_n |-> flash_o.chip_sel_n)
        else $error("flash selected during reset");
    wake_wait_a: assert property ($rose(flash_o.reset_powerdown_n) |-> flash_o.chip_sel_n[*8])
        else $error("access too soon after reset");
    bus_gap_a: assert property ($rose(flash_o.chip_sel_n) |-> flash_o.data_lines_oe_n)
        else $error("bus held at deselect");
endmodule
bind flash_host_ctrl flash_host_ctrl_sva chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .flash_o(flash_o));

// ==== tb/flash_dev_model.sv ====
/* behavioural flash device facing the host controller.
   assumes host pins and a data bus resolved by the bench. */
`timescale 1ns/100ps
module flash_dev_model (
    input  wire flash_host_pkg::flash_out_type pins_i,  // host pins
    input  wire logic [15:0]                   dq_i,    // resolved bus
    output logic                               drive_o, // device drives bus
    output logic [15:0]                        dq_o     // device bus value
);
    logic [15:0] mem [256];          // low array words
    logic [15:0] lock_word = 16'hFFFF; // otp lock bits, only clear
    logic [15:0] last      = 16'h0000; // last value driven
    logic [7:0]  pend      = 8'h00;  // first write of a pair
    logic        id_mode   = 1'b0;   // identifier read mode
    logic [7:0]  a;                  // latched word index
    initial for (int i = 0; i < 256; i++) mem[i] = {8'hA5, i[7:0]};
    // drive only when selected and enabled, else a changing value
    assign drive_o = pins_i.reset_powerdown_n && !pins_i.chip_sel_n && !pins_i.out_en_n;
    always @(*) begin
        if (drive_o) begin
            dq_o = (id_mode && pins_i.addr == 21'h000080) ? lock_word : mem[pins_i.addr[7:0]];
            last = dq_o;
        end else dq_o = ~last;
    end
    // reset returns to array mode, drops any pending pair
    always @(negedge pins_i.reset_powerdown_n) begin
        id_mode = 1'b0;
        pend = 8'h00;
    end
    // latch on whichever strobe rises first, both must be low before
    always @(posedge pins_i.write_en_n or posedge pins_i.chip_sel_n) begin
        a = pins_i.addr[7:0];
        if (pins_i.reset_powerdown_n && !(pins_i.write_en_n && pins_i.chip_sel_n)) begin
            if (pend == 8'hC0 && pins_i.addr == 21'h000080) lock_word = lock_word & dq_i;
            else if (pend == 8'hC0 && lock_word[1]) mem[a] = mem[a] & dq_i;
            else if (pend == 8'h40) mem[a] = mem[a] & dq_i;
            else if (pend == 8'h00 && dq_i[7:0] == 8'h90) id_mode = 1'b1;
            else if (pend == 8'h00 && dq_i[7:0] == 8'hFF) id_mode = 1'b0;
            pend = (pend == 8'h00 && (dq_i[7:0] == 8'hC0 || dq_i[7:0] == 8'h40)) ? dq_i[7:0] : 8'h00;
        end
    end
endmodule

// ==== tb/test_flash_host_ctrl.sv ====
/* self-checking bench for the flash host controller.
   assumes the device model and the checker are compiled before it. */
`timescale 1ns/100ps
module test_flash_host_ctrl;
    logic        ref_clk_i = 1'b0, rst_i = 1'b1; // clock, reset
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0; // apb controls
    logic [11:0] paddr_i  = 12'h000;              // apb address
    logic [31:0] pwdata_i = 32'h00000000, prdata_o, q; // apb data, last read
    logic        pready_o, pslverr_o, err, drive;  // answers
    logic [15:0] dev_dq, dq;                       // device value, resolved bus
    flash_host_pkg::flash_out_type flash_o;        // host pins
    int          num_errors = 0, checks_done = 0;  // tallies
    assign dq = flash_o.data_lines_oe_n ? dev_dq : flash_o.data_lines;
    flash_host_ctrl #(.RESET_TO_OUTPUT_NS(500), .RESET_TO_WRITE_NS(500)) DUT (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .data_lines_i(dq),
        .ready_busy_n_i(1'b1), .flash_o(flash_o));
    flash_dev_model dev (.pins_i(flash_o), .dq_i(dq), .drive_o(drive), .dq_o(dev_dq));
    initial forever #5 ref_clk_i = ~ref_clk_i;
    task automatic end_of_test;
        if (num_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
            if (q[0] === 1'b0) return;
        end
        chk("busy", 32'h0, q);
    endtask
    // load address and data, start, wait, fetch read result
    task automatic op(input logic [2:0] c, input logic [7:0] cmd, input logic [20:0] a,
                      input logic [15:0] d);
        apb(1'b1, flash_host_pkg::OFS_ADDR, {11'h000, a});
        apb(1'b1, flash_host_pkg::OFS_WDATA, {16'h0000, d});
        apb(1'b1, flash_host_pkg::OFS_CTRL, {16'h0000, cmd, 5'h00, c});
        wait_idle;
        apb(1'b0, flash_host_pkg::OFS_RDATA, 32'h0);
    endtask
    task automatic test_regs;
        repeat (12) @(posedge ref_clk_i);
        apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
        chk("status in recovery", 32'h7, q);
        apb(1'b1, flash_host_pkg::OFS_TIMING, 32'h1);
        apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
        chk("refused write", 32'hF, q);
        wait_idle;
        apb(1'b1, flash_host_pkg::OFS_STATUS, 32'h8);
        apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
        chk("status idle", 32'h2, q);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1'b0, flash_host_pkg::OFS_TIMING, 32'h0);
        chk("timing reset", 32'h4, q);
        apb(1'b1, flash_host_pkg::OFS_TIMING, 32'h1);
        apb(1'b0, flash_host_pkg::OFS_TIMING, 32'h0);
        chk("timing floor", 32'h2, q);
    endtask
    task automatic test_array;
        op(flash_host_pkg::OP_READ, 8'h00, 21'h000003, 16'h0000);
        chk("array read", 32'hA503, q);
        op(flash_host_pkg::OP_SEQ, 8'h40, 21'h000005, 16'h1234);
        op(flash_host_pkg::OP_READ, 8'h00, 21'h000005, 16'h0000);
        chk("programmed word", 32'hA505 & 32'h1234, q);
    endtask
    task automatic test_otp;
        op(flash_host_pkg::OP_OTP_LOCK, 8'hC0, 21'h000000, 16'h0000);
        op(flash_host_pkg::OP_CMD, 8'h90, 21'h000000, 16'h0000);
        op(flash_host_pkg::OP_READ, 8'h00, 21'h000080, 16'h0000);
        chk("otp lock word", 32'hFFFD, q);
        apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
        chk("id mode flag", 32'h12, q);
        op(flash_host_pkg::OP_RESET, 8'h00, 21'h000000, 16'h0000);
        op(flash_host_pkg::OP_READ, 8'h00, 21'h000080, 16'h0000);
        chk("array after reset", 32'hA580, q);
        apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
        chk("id flag after reset", 32'h2, q);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        test_regs;
        test_array;
        test_otp;
        end_of_test;
    end
    initial begin
        #200000;
        num_errors++;
        end_of_test;
    end
endmodule
